/* inc/lirc_consts.vh */
`ifndef LIRC_CONSTS_VH
`define LIRC_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define LIRC_ADDR_RATIO_B3 8'h2C
`define LIRC_ADDR_RATIO_B2 8'h2D
`define LIRC_ADDR_RATIO_B1 8'h2E
`define LIRC_ADDR_RATIO_B0 8'h2F
`define LIRC_ADDR_CTRL 8'h30
`define LIRC_ADDR_RANK 8'h31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LIRC_RST_RATIO 32'h0001_0001
`define LIRC_RST_CTRL 8'h0C
`define LIRC_RST_RANK 8'h32

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LIRC_DEN_MSB 15
`define LIRC_DEN_LSB 0
`define LIRC_NUM_MSB 31
`define LIRC_NUM_LSB 16
`define LIRC_SLEW_MSB 3
`define LIRC_SLEW_LSB 2
`define LIRC_REALIGN_BIT 4
`define LIRC_BW_MSB 7
`define LIRC_BW_LSB 5
`define LIRC_RANK2_MSB 2
`define LIRC_RANK2_LSB 0
`define LIRC_RANK3_MSB 6
`define LIRC_RANK3_LSB 4

// ----------------------------------------------------------------
// encodings and decoded values
// ----------------------------------------------------------------
`define LIRC_RANK_EXCLUDED 3'h7
`define LIRC_BW_CUSTOM 3'h7
// slew caps in ns per second; zero means no cap
`define LIRC_SLEW_NS_00 17'h0_EE48
`define LIRC_SLEW_NS_01 17'h0_1D4C
`define LIRC_SLEW_NS_10 17'h0_0375
`define LIRC_SLEW_NS_11 17'h0_0000
// base bandwidth 14 Hz, doubled per code step
`define LIRC_BW_BASE_HZ 10'h00E
// divider step count for a 48 bit dividend
`define LIRC_DIV_STEPS 6'h30

`endif

/* verilog/lirc_rank_select.v */
`timescale 1ns/1ns
`include "lirc_consts.vh"

module lirc_rank_select (
    // clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // control
    input wire auto_mode_i,
    input wire [2:0] rank2_i,
    input wire [2:0] rank3_i,
    // availability from reference monitors, same clock
    input wire avail2_i,
    input wire avail3_i,
    // selection
    output reg sel_valid_o,
    output reg sel_is3_o
);

// ----------------------------------------------------------------
// candidate qualification
// ----------------------------------------------------------------
// excluded code never qualifies
wire ok2 = avail2_i && (rank2_i != `LIRC_RANK_EXCLUDED);
wire ok3 = avail3_i && (rank3_i != `LIRC_RANK_EXCLUDED);
// best pick when free to choose; tie goes to input 2
wire best_is3 = ok3 && (!ok2 || (rank3_i < rank2_i));

reg valid_next;
reg is3_next;

// ----------------------------------------------------------------
// switching decision
// ----------------------------------------------------------------
always @* begin
    valid_next = sel_valid_o;
    is3_next = sel_is3_o;
    if (auto_mode_i) begin
        if (sel_valid_o && sel_is3_o && ok3) begin
            if (ok2 && (rank2_i < rank3_i)) begin
                is3_next = 1'b0;
            end
        end else if (sel_valid_o && !sel_is3_o && ok2) begin
            if (ok3 && (rank3_i < rank2_i)) begin
                is3_next = 1'b1;
            end
        end else begin
            // current failed or none: take best available
            valid_next = ok2 || ok3;
            is3_next = best_is3;
        end
    end
end

// selection state; frozen outside automatic mode
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        sel_valid_o <= 1'b0;
        sel_is3_o <= 1'b0;
    end else begin
        sel_valid_o <= valid_next;
        sel_is3_o <= is3_next;
    end
end

endmodule // lirc_rank_select

/* verilog/lirc_regs.v */
`timescale 1ns/1ns
`include "lirc_consts.vh"

// Function
// - 32-bit ratio register, reset 0x00010001
// - nominal rate is base*multiplier*num/den
// - control bits 3:2 pick slew cap
// - control bit 4 realigns output phase
// - control bits 7:5 pick fixed bandwidth
// - code 111 uses custom bandwidth register
// - input 2 rank in bits 2:0
// - revert to lower rank code when available
// - equal ranks do not switch back
// - mixed ranks combine both switching styles
// - input 3 rank in bits 6:4

module lirc_regs (
    // clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // byte register port from serial port engine
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // neighbouring registers and loop status, same clock
    input wire [15:0] input3_base_rate_i,
    input wire [15:0] input3_rate_multiplier_i,
    input wire [7:0] loop0_custom_bandwidth_i,
    input wire auto_mode_i,
    input wire avail2_i,
    input wire avail3_i,
    // decoded loop controls
    output reg [16:0] loop0_slew_cap_ns_o,
    output reg loop0_slew_unlimited_o,
    output reg loop0_phase_realign_enable_o,
    output reg [9:0] loop0_filter_bandwidth_hz_o,
    output reg loop0_bw_custom_o,
    output reg [7:0] loop0_bw_custom_value_o,
    // nominal input 3 rate
    output reg [47:0] input3_nominal_hz_o,
    output reg input3_nominal_valid_o,
    output reg input3_ratio_error_o,
    // reference selection
    output wire sel_valid_o,
    output wire sel_is3_o
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg [31:0] ratio_reg; // input 3 rate ratio, whole word
reg [7:0] ctrl_reg; // loop 0 control byte
reg [7:0] rank_reg; // loop 0 input 2/3 ranks

wire [15:0] input3_ratio_denominator = ratio_reg[`LIRC_DEN_MSB:`LIRC_DEN_LSB];
wire [15:0] input3_ratio_numerator = ratio_reg[`LIRC_NUM_MSB:`LIRC_NUM_LSB];
wire [1:0] loop0_phase_slew_cap = ctrl_reg[`LIRC_SLEW_MSB:`LIRC_SLEW_LSB];
wire [2:0] loop0_filter_bandwidth = ctrl_reg[`LIRC_BW_MSB:`LIRC_BW_LSB];
wire [2:0] loop0_input2_rank = rank_reg[`LIRC_RANK2_MSB:`LIRC_RANK2_LSB];
wire [2:0] loop0_input3_rank = rank_reg[`LIRC_RANK3_MSB:`LIRC_RANK3_LSB];

// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
// byte writes land directly; the host keeps a word consistent by
// writing all four bytes, so a half-written ratio is briefly visible
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        ratio_reg <= `LIRC_RST_RATIO;
        ctrl_reg <= `LIRC_RST_CTRL;
        rank_reg <= `LIRC_RST_RANK;
    end else if (reg_wr_i) begin
        case (reg_addr_i)
            `LIRC_ADDR_RATIO_B3: begin
                ratio_reg[31:24] <= reg_wdata_i;
            end
            `LIRC_ADDR_RATIO_B2: begin
                ratio_reg[23:16] <= reg_wdata_i;
            end
            `LIRC_ADDR_RATIO_B1: begin
                ratio_reg[15:8] <= reg_wdata_i;
            end
            `LIRC_ADDR_RATIO_B0: begin
                ratio_reg[7:0] <= reg_wdata_i;
            end
            `LIRC_ADDR_CTRL: begin
                ctrl_reg <= reg_wdata_i;
            end
            `LIRC_ADDR_RANK: begin
                rank_reg <= reg_wdata_i;
            end
            default: begin
                // other addresses belong to other banks
            end
        endcase
    end
end

// ----------------------------------------------------------------
// register reads
// ----------------------------------------------------------------
// one cycle after the read strobe; unmapped reads give zero
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        reg_rdata_o <= 8'h00;
        reg_rvalid_o <= 1'b0;
    end else begin
        reg_rvalid_o <= reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LIRC_ADDR_RATIO_B3: reg_rdata_o <= ratio_reg[31:24];
                `LIRC_ADDR_RATIO_B2: reg_rdata_o <= ratio_reg[23:16];
                `LIRC_ADDR_RATIO_B1: reg_rdata_o <= ratio_reg[15:8];
                `LIRC_ADDR_RATIO_B0: reg_rdata_o <= ratio_reg[7:0];
                `LIRC_ADDR_CTRL: reg_rdata_o <= ctrl_reg;
                `LIRC_ADDR_RANK: reg_rdata_o <= rank_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// loop control decode
// ----------------------------------------------------------------
reg [16:0] slew_next;

// slew cap table
always @* begin
    case (loop0_phase_slew_cap)
        2'b00: slew_next = `LIRC_SLEW_NS_00;
        2'b01: slew_next = `LIRC_SLEW_NS_01;
        2'b10: slew_next = `LIRC_SLEW_NS_10;
        default: slew_next = `LIRC_SLEW_NS_11;
    endcase
end

// registered decode so outputs leave from flops
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        loop0_slew_cap_ns_o <= 17'h0_0000;
        loop0_slew_unlimited_o <= 1'b0;
        loop0_phase_realign_enable_o <= 1'b0;
        loop0_filter_bandwidth_hz_o <= 10'h000;
        loop0_bw_custom_o <= 1'b0;
        loop0_bw_custom_value_o <= 8'h00;
    end else begin
        loop0_slew_cap_ns_o <= slew_next;
        loop0_slew_unlimited_o <= (loop0_phase_slew_cap == 2'b11);
        loop0_phase_realign_enable_o <= ctrl_reg[`LIRC_REALIGN_BIT];
        // 14 Hz doubled per code step
        loop0_filter_bandwidth_hz_o <= `LIRC_BW_BASE_HZ << loop0_filter_bandwidth;
        // custom code hands over to custom register
        loop0_bw_custom_o <= (loop0_filter_bandwidth == `LIRC_BW_CUSTOM);
        loop0_bw_custom_value_o <= loop0_custom_bandwidth_i;
    end
end

// ----------------------------------------------------------------
// nominal rate: base * multiplier * num / den
// ----------------------------------------------------------------
// a serial divider keeps area small at the cost of 48 cycles latency;
// it restarts continuously so it follows register changes
localparam ST_LOAD = 2'b01;
localparam ST_RUN = 2'b10;

reg [1:0] state_reg;
reg [47:0] quo_reg; // dividend shifting into quotient
reg [16:0] rem_reg; // partial remainder
reg [15:0] den_reg; // latched denominator
reg [5:0] cnt_reg; // steps left

wire [47:0] product = {32'h0000_0000, input3_base_rate_i} *
    {32'h0000_0000, input3_rate_multiplier_i} * {32'h0000_0000, input3_ratio_numerator};
wire [16:0] shifted = {rem_reg[15:0], quo_reg[47]};
wire fits = (shifted >= {1'b0, den_reg});
wire [16:0] reduced = shifted - {1'b0, den_reg};

// divider sequencing
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        state_reg <= ST_LOAD;
        quo_reg <= 48'h0000_0000_0000;
        rem_reg <= 17'h0_0000;
        den_reg <= 16'h0000;
        cnt_reg <= 6'h00;
        input3_nominal_hz_o <= 48'h0000_0000_0000;
        input3_nominal_valid_o <= 1'b0;
        input3_ratio_error_o <= 1'b0;
    end else begin
        case (state_reg)
            ST_LOAD: begin
                // latch operands of the rate formula
                quo_reg <= product;
                rem_reg <= 17'h0_0000;
                den_reg <= input3_ratio_denominator;
                cnt_reg <= `LIRC_DIV_STEPS;
                state_reg <= ST_RUN;
            end
            ST_RUN: begin
                if (fits) begin
                    rem_reg <= reduced;
                    quo_reg <= {quo_reg[46:0], 1'b1};
                end else begin
                    rem_reg <= shifted;
                    quo_reg <= {quo_reg[46:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01) begin
                    state_reg <= ST_LOAD;
                    input3_nominal_valid_o <= 1'b1;
                    // zero denominator has no rate; report zero
                    input3_ratio_error_o <= (den_reg == 16'h0000);
                    if (den_reg == 16'h0000) begin
                        input3_nominal_hz_o <= 48'h0000_0000_0000;
                    end else begin
                        input3_nominal_hz_o <= {quo_reg[46:0], fits};
                    end
                end
            end
            default: begin
                state_reg <= ST_LOAD;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// automatic reference switching between inputs 2 and 3
// ----------------------------------------------------------------
// ranks steer the selector
lirc_rank_select u_sel (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .auto_mode_i(auto_mode_i),
    .rank2_i(loop0_input2_rank),
    .rank3_i(loop0_input3_rank),
    .avail2_i(avail2_i),
    .avail3_i(avail3_i),
    .sel_valid_o(sel_valid_o),
    .sel_is3_o(sel_is3_o)
);

endmodule // lirc_regs

/* verif/lirc_regs_asserts.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// checker for the loop 0 / input 3 register bank
// ------------------------------------------------------------
module lirc_regs_chk (
    // clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // byte register port
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    // decoded loop controls
    input wire [16:0] loop0_slew_cap_ns_o,
    input wire loop0_slew_unlimited_o,
    input wire loop0_phase_realign_enable_o,
    input wire [9:0] loop0_filter_bandwidth_hz_o,
    input wire loop0_bw_custom_o,
    // reference selection
    input wire auto_mode_i,
    input wire avail2_i,
    input wire avail3_i,
    input wire sel_valid_o,
    input wire sel_is3_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // slew cap in ns per second, zero when uncapped
    function automatic logic [16:0] slew_ns(input logic [1:0] c);
        return (c == 2'b00) ? 17'h0_EE48 : (c == 2'b01) ? 17'h0_1D4C :
            (c == 2'b10) ? 17'h0_0375 : 17'h0_0000;
    endfunction

    // control byte written
    sequence ctrl_wr;
        reg_wr_i && reg_addr_i == 8'h30;
    endsequence
    // mapped write, then read of the same byte on the next cycle
    sequence wr_rd;
        reg_wr_i && reg_addr_i >= 8'h2C && reg_addr_i <= 8'h31 ##1 reg_rd_i && $stable(reg_addr_i);
    endsequence

    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered after one cycle");
    chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read");
    chk_wr_readback: assert property (wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("byte read back differs from written");
    chk_unmapped_zero: assert property (
        reg_rd_i && (reg_addr_i < 8'h2C || reg_addr_i > 8'h31) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_realign_bit: assert property (ctrl_wr |=> ##1
        loop0_phase_realign_enable_o == $past(reg_wdata_i[4], 2))
        else $error("realign enable wrong");
    chk_slew_code: assert property (ctrl_wr |=> ##1 loop0_slew_cap_ns_o ==
        slew_ns($past(reg_wdata_i[3:2], 2)) && loop0_slew_unlimited_o ==
        ($past(reg_wdata_i[3:2], 2) == 2'b11))
        else $error("slew cap decode wrong");
    chk_bw_custom: assert property (ctrl_wr |=> ##1
        loop0_bw_custom_o == (&$past(reg_wdata_i[7:5], 2)))
        else $error("custom bandwidth flag wrong");
    chk_bw_hz: assert property ((ctrl_wr and reg_wdata_i[7:5] != 3'h7) |=> ##1
        loop0_filter_bandwidth_hz_o == (10'h00E << $past(reg_wdata_i[7:5], 2)))
        else $error("filter bandwidth wrong");
    chk_sel_none: assert property (auto_mode_i && !avail2_i && !avail3_i |=> !sel_valid_o)
        else $error("selection kept with no input available");
    chk_sel_frozen: assert property (!auto_mode_i |=>
        $stable(sel_valid_o) && $stable(sel_is3_o))
        else $error("selection moved outside automatic mode");
endmodule // lirc_regs_chk

bind lirc_regs lirc_regs_chk u_chk (.mclk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .loop0_slew_cap_ns_o, .loop0_slew_unlimited_o,
    .loop0_phase_realign_enable_o, .loop0_filter_bandwidth_hz_o, .loop0_bw_custom_o,
    .auto_mode_i, .avail2_i, .avail3_i, .sel_valid_o, .sel_is3_o);

/* verif/lirc_host_model.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// host side of the byte register port
// ------------------------------------------------------------
module lirc_host_model (
    // clock
    input wire mclk_i,
    // byte register port
    output logic [7:0] reg_addr_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_rd_o = 1'b0
);
    // one access, launched just after an edge, sampled at the next
    task put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_o <= w;
        reg_rd_o <= r;
        reg_addr_o <= a;
        reg_wdata_o <= d;
    endtask

    // strobes dropped; data no longer holds the last byte
    task idle();
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_wdata_o <= ~reg_wdata_o;
    endtask

    task wr32(input logic [7:0] a, input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            put(1'b1, 1'b0, a + 8'(i), v[31 - 8 * i -: 8]);
        end
        idle();
    endtask
endmodule // lirc_host_model

/* verif/tb_top.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module tb_top;
    logic mclk_i = 1'b0, rstn_i = 1'b0, auto_mode_i = 1'b0, avail2_i = 1'b0, avail3_i = 1'b0;
    logic [15:0] input3_base_rate_i = 16'h9C40, input3_rate_multiplier_i = 16'h0F30;
    logic [7:0] loop0_custom_bandwidth_i = 8'h00;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, loop0_bw_custom_value_o;
    wire reg_wr_i, reg_rd_i, reg_rvalid_o, loop0_slew_unlimited_o, loop0_phase_realign_enable_o;
    wire loop0_bw_custom_o, input3_nominal_valid_o, input3_ratio_error_o, sel_valid_o, sel_is3_o;
    wire [16:0] loop0_slew_cap_ns_o;
    wire [9:0] loop0_filter_bandwidth_hz_o;
    wire [47:0] input3_nominal_hz_o;
    int miscompares = 0, comparisons = 0;
    logic [7:0] exp_q[$], d;
    logic [7:0] rst_v [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h0C, 8'h32};
    logic [16:0] sl [4] = '{17'h0_EE48, 17'h0_1D4C, 17'h0_0375, 17'h0_0000};
    logic [47:0] e48;

    lirc_regs dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .input3_base_rate_i(input3_base_rate_i),
        .input3_rate_multiplier_i(input3_rate_multiplier_i),
        .loop0_custom_bandwidth_i(loop0_custom_bandwidth_i), .auto_mode_i(auto_mode_i),
        .avail2_i(avail2_i), .avail3_i(avail3_i), .loop0_slew_cap_ns_o(loop0_slew_cap_ns_o),
        .loop0_slew_unlimited_o(loop0_slew_unlimited_o),
        .loop0_phase_realign_enable_o(loop0_phase_realign_enable_o),
        .loop0_filter_bandwidth_hz_o(loop0_filter_bandwidth_hz_o),
        .loop0_bw_custom_o(loop0_bw_custom_o),
        .loop0_bw_custom_value_o(loop0_bw_custom_value_o),
        .input3_nominal_hz_o(input3_nominal_hz_o),
        .input3_nominal_valid_o(input3_nominal_valid_o),
        .input3_ratio_error_o(input3_ratio_error_o), .sel_valid_o(sel_valid_o),
        .sel_is3_o(sel_is3_o));
    lirc_host_model host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

    initial forever #4 mclk_i = ~mclk_i;

    task check(input string n, input logic [47:0] s, input logic [47:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // read with its expected byte noted for the monitor
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.put(1'b0, 1'b1, a, 8'h00);
        host.idle();
    endtask

    // let n edges pass, then look once outputs settled
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // change availability, then check the selection
    task av(input logic a2, input logic a3, input logic ev, input logic e3);
        @(posedge mclk_i);
        avail2_i <= a2;
        avail3_i <= a3;
        wt(3);
        check("sel_valid", sel_valid_o, ev);
        check("sel_is3", sel_is3_o, e3);
    endtask

    // oldest note against each answered read
    always @(negedge mclk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            check("rdata", reg_rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(50437));
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        loop0_custom_bandwidth_i <= 8'($urandom);
        for (int i = 0; i < 6; i++) rd(8'h2C + 8'(i), rst_v[i]);
        wt(2);
        check("unlimited", loop0_slew_unlimited_o, 1'b1);
        check("bw_hz", loop0_filter_bandwidth_hz_o, 10'h00E);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], 1'($urandom), i[1:0], 2'($urandom)};
            exp_q.push_back(d);
            host.put(1'b1, 1'b0, 8'h30, d);
            host.put(1'b0, 1'b1, 8'h30, 8'h00);
            host.idle();
            wt(2);
            check("bw_custom", loop0_bw_custom_o, i == 7);
            if (i < 7) check("bw_hz", loop0_filter_bandwidth_hz_o, 10'h00E << i);
            check("custom_value", loop0_bw_custom_value_o, loop0_custom_bandwidth_i);
            check("slew_ns", loop0_slew_cap_ns_o, sl[i % 4]);
            check("unlimited", loop0_slew_unlimited_o, i % 4 == 3);
            check("realign", loop0_phase_realign_enable_o, d[4]);
        end
        // realign back low for hitless switching
        host.put(1'b1, 1'b0, 8'h30, 8'h0C);
        host.idle();
        $display("control test done");
        input3_base_rate_i <= 16'($urandom);
        input3_rate_multiplier_i <= 16'($urandom);
        host.wr32(8'h2C, 32'h00FF_00ED);
        for (int i = 0; i < 4; i++) rd(8'h2C + 8'(i), 8'(32'h00FF_00ED >> (24 - 8 * i)));
        e48 = 48'(input3_base_rate_i) * input3_rate_multiplier_i * 48'h00FF / 48'h00ED;
        wt(100);
        check("nominal", input3_nominal_hz_o, e48);
        check("nominal_valid", input3_nominal_valid_o, 1'b1);
        check("ratio_error", input3_ratio_error_o, 1'b0);
        host.put(1'b1, 1'b0, 8'h2E, 8'h00);
        host.put(1'b1, 1'b0, 8'h2F, 8'h00);
        host.idle();
        wt(100);
        check("nominal", input3_nominal_hz_o, 48'h0);
        check("ratio_error", input3_ratio_error_o, 1'b1);
        // ratio back to one for a plain reference
        host.wr32(8'h2C, 32'h0001_0001);
        wt(100);
        e48 = 48'(input3_base_rate_i) * input3_rate_multiplier_i;
        check("nominal", input3_nominal_hz_o, e48);
        check("ratio_error", input3_ratio_error_o, 1'b0);
        host.put(1'b1, 1'b0, 8'h32, 8'hA5);
        host.idle();
        rd(8'h32, 8'h00);
        rd(8'h2B, 8'h00);
        $display("ratio test done");
        auto_mode_i <= 1'b1;
        av(1'b1, 1'b1, 1'b1, 1'b0);
        av(1'b0, 1'b1, 1'b1, 1'b1);
        av(1'b1, 1'b1, 1'b1, 1'b0);
        host.put(1'b1, 1'b0, 8'h31, 8'h22);
        host.idle();
        av(1'b0, 1'b1, 1'b1, 1'b1);
        av(1'b1, 1'b1, 1'b1, 1'b1);
        host.put(1'b1, 1'b0, 8'h31, 8'h17);
        host.idle();
        rd(8'h31, 8'h17);
        av(1'b1, 1'b1, 1'b1, 1'b1);
        av(1'b1, 1'b0, 1'b0, 1'b0);
        av(1'b0, 1'b0, 1'b0, 1'b0);
        // selection frozen outside automatic mode
        @(posedge mclk_i);
        auto_mode_i <= 1'b0;
        av(1'b1, 1'b1, 1'b0, 1'b0);
        $display("selector test done");
        wt(2);
        check("pending", exp_q.size(), 0);
        finish_test();
    end
endmodule // tb_top
